// >>> common/conv_cfg_pkg.sv
// Constants and types shared by the converter configuration block
package conv_cfg_pkg;

   // ------------------------------------------------------------
   // Register addresses on the serial control port
   // ------------------------------------------------------------
   localparam logic [12:0] SYNC_CONTROL_ADDR    = 13'h100;
   localparam logic [12:0] USER_CONFIG_TWO_ADDR = 13'h101;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MASTER_SYNC_BIT    = 0;
   localparam int DIV_SYNC_EN_BIT    = 1;
   localparam int NEXT_SYNC_ONLY_BIT = 2;
   localparam int OE_PIN_EN_BIT      = 7;
   localparam int DETECT_EN_BIT      = 3;
   localparam int FORCE_OSC_BIT      = 2;
   localparam int PULLDOWN_DIS_BIT   = 0;

   // ------------------------------------------------------------
   // Writable masks and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] SYNC_CONTROL_MASK     = 8'h07;
   localparam logic [7:0] USER_CONFIG_TWO_MASK  = 8'h8D;
   localparam logic [7:0] SYNC_CONTROL_RESET    = 8'h01;
   localparam logic [7:0] USER_CONFIG_TWO_RESET = 8'h88;
   localparam logic [7:0] READ_UNMAPPED         = 8'h00;

   // ------------------------------------------------------------
   // Serial frame layout: 16-bit instruction, one data byte
   // ------------------------------------------------------------
   localparam int          READ_FLAG_BIT = 15;
   localparam int          ADDR_MSB      = 12;
   localparam logic [4:0]  INSTR_LAST    = 5'h0F;
   localparam logic [4:0]  DATA_LAST     = 5'h07;
   localparam logic [4:0]  CNT_ZERO      = 5'h00;
   localparam logic [4:0]  CNT_ONE       = 5'h01;

   // ------------------------------------------------------------
   // Low encode rate detector timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 8;
   localparam int LOW_RATE_MSPS   = 5;
   // Longest encode period still counted as fast, in ref_clk cycles
   localparam int LOW_RATE_CYCLES = 1000 / (CLK_PERIOD_NS * LOW_RATE_MSPS);
   localparam logic [7:0] LOW_RATE_COUNT = 8'(LOW_RATE_CYCLES);
   localparam logic [7:0] DET_CNT_ZERO   = 8'h00;
   localparam logic [7:0] DET_CNT_ONE    = 8'h01;

   // ------------------------------------------------------------
   // Serial frame states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      st_idle  = 4'b0001,
      st_instr = 4'b0010,
      st_data  = 4'b0100,
      st_done  = 4'b1000
   } frame_state_t;

endpackage

// >>> src/low_rate_detector.sv
// Encode clock period watcher that flags a low sample rate
`timescale 1ns/1ps
module low_rate_detector (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic detect_enable,
   input  wire logic encode_clk,
   output logic      low_rate_reg
);

   logic       encode_prev_reg;
   logic [7:0] period_cnt_reg;
   logic       encode_rise;

   assign encode_rise = encode_clk & ~encode_prev_reg;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         encode_prev_reg <= 1'b0;
      end else begin
         encode_prev_reg <= encode_clk;
      end
   end

   // ------------------------------------------------------------
   // Period counter; a stopped encode clock also reads as low rate
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         period_cnt_reg <= conv_cfg_pkg::DET_CNT_ZERO;
         low_rate_reg   <= 1'b0;
      end else if (!detect_enable) begin
         period_cnt_reg <= conv_cfg_pkg::DET_CNT_ZERO;
         low_rate_reg   <= 1'b0;
      end else if (encode_rise) begin
         period_cnt_reg <= conv_cfg_pkg::DET_CNT_ZERO;
         low_rate_reg   <= (period_cnt_reg >= conv_cfg_pkg::LOW_RATE_COUNT);
      end else if (period_cnt_reg >= conv_cfg_pkg::LOW_RATE_COUNT) begin
         low_rate_reg   <= 1'b1;
      end else begin
         period_cnt_reg <= period_cnt_reg + conv_cfg_pkg::DET_CNT_ONE;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   slow_flag_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      detect_enable && period_cnt_reg >= conv_cfg_pkg::LOW_RATE_COUNT
      ##1 detect_enable |-> low_rate_reg)
      else $error("slow encode clock not flagged");

   det_off_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      !detect_enable |=> !low_rate_reg)
      else $error("disabled detector still flags low rate");

endmodule

// >>> src/sync_and_user_config_regs.sv
// Sync control and user configuration registers behind the serial port
`timescale 1ns/1ps
// Operation
// - Sync functions are ignored unless master sync enable is high.
// - Sync pulse reaches divider only when divider and master enables high.
// - Next-sync-only low: every sync pulse resynchronizes the divider.
// - Next-sync-only high: divider aligns to first pulse, later pulses ignored.
// - After that one-shot alignment, divider sync enable clears itself.
// - Output-enable pin controls outputs only when its enable bit is high.
// - Detect bit high runs a detector flagging encode rates below 5 MSPS.
// - Detected low rate starts the internal low-rate oscillator.
// - Detect bit low disables the low-rate detector completely.
// - Force bit high keeps the internal oscillator running regardless.
// - Pull-down disable bit high disconnects the serial data pull-down.
module sync_and_user_config_regs (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic serial_clk,
   input  wire logic serial_select_line_n,
   input  wire logic sdio_in,
   output logic      sdio_out,
   output logic      sdio_oe,
   output logic      sdio_pulldown_en,
   input  wire logic sync_in,
   output logic      divider_sync_pulse,
   input  wire logic output_enable_pin_gate_n,
   output logic      outputs_enabled,
   input  wire logic encode_clk,
   output logic      low_rate_detected,
   output logic      low_rate_internal_oscillator_run
);

   conv_cfg_pkg::frame_state_t state_reg;
   logic [4:0]  bit_cnt_reg;
   logic [15:0] instr_reg;
   logic [7:0]  data_shift_reg;
   logic [7:0]  rd_shift_reg;
   logic        sclk_prev_reg;
   logic        sync_prev_reg;
   logic [7:0]  sync_control_reg;
   logic [7:0]  user_config_two_reg;
   logic        sdio_out_reg;
   logic        sdio_oe_reg;
   logic        div_pulse_reg;
   logic        outputs_enabled_reg;
   logic        osc_run_reg;
   logic        low_rate_reg;

   logic        sclk_rise;
   logic        sclk_fall;
   logic        is_read;
   logic [12:0] frame_addr;
   logic [12:0] instr_next_addr;
   logic        instr_done;
   logic        wr_stb;
   logic [7:0]  wr_data;
   logic        sync_rise;
   logic        sync_fire;
   logic        one_shot_done;

   // ------------------------------------------------------------
   // Pin edge detection
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sclk_prev_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= serial_clk;
         sync_prev_reg <= sync_in;
      end
   end

   assign sclk_rise = serial_clk & ~sclk_prev_reg;
   assign sclk_fall = ~serial_clk & sclk_prev_reg;
   assign sync_rise = sync_in & ~sync_prev_reg;

   // ------------------------------------------------------------
   // Serial frame sequencing
   // ------------------------------------------------------------
   assign is_read    = instr_reg[conv_cfg_pkg::READ_FLAG_BIT];
   assign frame_addr = instr_reg[conv_cfg_pkg::ADDR_MSB:0];
   // Address as it stands once the last instruction bit is shifted in
   assign instr_next_addr = {instr_reg[conv_cfg_pkg::ADDR_MSB-1:0], sdio_in};
   assign instr_done = sclk_rise && (state_reg == conv_cfg_pkg::st_instr)
                       && (bit_cnt_reg == conv_cfg_pkg::INSTR_LAST);
   assign wr_stb  = sclk_rise && (state_reg == conv_cfg_pkg::st_data)
                    && (bit_cnt_reg == conv_cfg_pkg::DATA_LAST) && !is_read;
   assign wr_data = {data_shift_reg[6:0], sdio_in};

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_reg   <= conv_cfg_pkg::st_idle;
         bit_cnt_reg <= conv_cfg_pkg::CNT_ZERO;
      end else if (serial_select_line_n) begin
         state_reg   <= conv_cfg_pkg::st_idle;
         bit_cnt_reg <= conv_cfg_pkg::CNT_ZERO;
      end else begin
         case (state_reg)
            conv_cfg_pkg::st_idle: begin
               state_reg   <= conv_cfg_pkg::st_instr;
               bit_cnt_reg <= conv_cfg_pkg::CNT_ZERO;
            end
            conv_cfg_pkg::st_instr: begin
               if (instr_done) begin
                  state_reg   <= conv_cfg_pkg::st_data;
                  bit_cnt_reg <= conv_cfg_pkg::CNT_ZERO;
               end else if (sclk_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + conv_cfg_pkg::CNT_ONE;
               end
            end
            conv_cfg_pkg::st_data: begin
               if (sclk_rise && bit_cnt_reg == conv_cfg_pkg::DATA_LAST) begin
                  state_reg <= conv_cfg_pkg::st_done;
               end else if (sclk_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + conv_cfg_pkg::CNT_ONE;
               end
            end
            conv_cfg_pkg::st_done: begin
               // Extra clocks in a frame are ignored; one byte per frame
               state_reg <= conv_cfg_pkg::st_done;
            end
            default: begin
               state_reg   <= conv_cfg_pkg::st_idle;
               bit_cnt_reg <= conv_cfg_pkg::CNT_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         instr_reg      <= 16'h0000;
         data_shift_reg <= 8'h00;
      end else if (sclk_rise && state_reg == conv_cfg_pkg::st_instr) begin
         instr_reg      <= {instr_reg[14:0], sdio_in};
      end else if (sclk_rise && state_reg == conv_cfg_pkg::st_data) begin
         data_shift_reg <= wr_data;
      end
   end

   // ------------------------------------------------------------
   // Read path: data launched on falling serial clock edges
   // ------------------------------------------------------------
   function automatic logic [7:0] read_value(input logic [12:0] addr,
                                             input logic [7:0]  sync_v,
                                             input logic [7:0]  cfg_v);
      logic [7:0] value;
      value = conv_cfg_pkg::READ_UNMAPPED;
      if (addr == conv_cfg_pkg::SYNC_CONTROL_ADDR) begin
         value = sync_v & conv_cfg_pkg::SYNC_CONTROL_MASK;
      end else if (addr == conv_cfg_pkg::USER_CONFIG_TWO_ADDR) begin
         value = cfg_v & conv_cfg_pkg::USER_CONFIG_TWO_MASK;
      end
      return value;
   endfunction

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_shift_reg <= 8'h00;
         sdio_out_reg <= 1'b0;
         sdio_oe_reg  <= 1'b0;
      end else if (serial_select_line_n) begin
         sdio_oe_reg  <= 1'b0;
      end else if (instr_done) begin
         rd_shift_reg <= read_value(instr_next_addr, sync_control_reg,
                                    user_config_two_reg);
      end else if (sclk_fall && is_read
                   && state_reg == conv_cfg_pkg::st_data) begin
         sdio_out_reg <= rd_shift_reg[7];
         sdio_oe_reg  <= 1'b1;
         rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
      end
   end

   assign sdio_out = sdio_out_reg;
   assign sdio_oe  = sdio_oe_reg;

   // ------------------------------------------------------------
   // Sync control register and divider sync gating
   // ------------------------------------------------------------
   assign sync_fire = sync_rise
                      && sync_control_reg[conv_cfg_pkg::MASTER_SYNC_BIT]
                      && sync_control_reg[conv_cfg_pkg::DIV_SYNC_EN_BIT];
   // One-shot mode consumes the enable on its first pulse
   assign one_shot_done = sync_fire
                    && sync_control_reg[conv_cfg_pkg::NEXT_SYNC_ONLY_BIT];

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sync_control_reg <= conv_cfg_pkg::SYNC_CONTROL_RESET;
      end else if (wr_stb && frame_addr == conv_cfg_pkg::SYNC_CONTROL_ADDR) begin
         // A host write re-arming the enable wins over the self-clear
         sync_control_reg <= wr_data & conv_cfg_pkg::SYNC_CONTROL_MASK;
      end else if (one_shot_done) begin
         sync_control_reg[conv_cfg_pkg::DIV_SYNC_EN_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         div_pulse_reg <= 1'b0;
      end else begin
         div_pulse_reg <= sync_fire;
      end
   end

   assign divider_sync_pulse = div_pulse_reg;

   // ------------------------------------------------------------
   // User configuration register and its controls
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         user_config_two_reg <= conv_cfg_pkg::USER_CONFIG_TWO_RESET;
      end else if (wr_stb
                   && frame_addr == conv_cfg_pkg::USER_CONFIG_TWO_ADDR) begin
         user_config_two_reg <= wr_data & conv_cfg_pkg::USER_CONFIG_TWO_MASK;
      end
   end

   low_rate_detector u_detector (
      .ref_clk       (ref_clk),
      .reset         (reset),
      .detect_enable (user_config_two_reg[conv_cfg_pkg::DETECT_EN_BIT]),
      .encode_clk    (encode_clk),
      .low_rate_reg  (low_rate_reg)
   );

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         outputs_enabled_reg <= 1'b1;
         osc_run_reg         <= 1'b0;
      end else begin
         // Pin ignored when its enable is low: outputs stay on
         outputs_enabled_reg <=
            !user_config_two_reg[conv_cfg_pkg::OE_PIN_EN_BIT]
            || !output_enable_pin_gate_n;
         osc_run_reg <= user_config_two_reg[conv_cfg_pkg::FORCE_OSC_BIT]
                        || low_rate_reg;
      end
   end

   assign outputs_enabled                  = outputs_enabled_reg;
   assign low_rate_detected                = low_rate_reg;
   assign low_rate_internal_oscillator_run = osc_run_reg;
   // Pull-down switch follows the register bit directly
   assign sdio_pulldown_en =
      !user_config_two_reg[conv_cfg_pkg::PULLDOWN_DIS_BIT];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence fire_cond_s;
      sync_rise && sync_control_reg[conv_cfg_pkg::MASTER_SYNC_BIT]
      && sync_control_reg[conv_cfg_pkg::DIV_SYNC_EN_BIT];
   endsequence

   sequence no_write_s;
      !(wr_stb && frame_addr == conv_cfg_pkg::SYNC_CONTROL_ADDR);
   endsequence

   master_gate_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      !sync_control_reg[conv_cfg_pkg::MASTER_SYNC_BIT] |=> !divider_sync_pulse)
      else $error("sync pulse passed with master enable low");

   div_gate_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      divider_sync_pulse |-> $past(sync_rise)
      && $past(sync_control_reg[conv_cfg_pkg::DIV_SYNC_EN_BIT]))
      else $error("sync pulse passed without divider enable");

   continuous_sync_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      fire_cond_s ##0 !sync_control_reg[conv_cfg_pkg::NEXT_SYNC_ONLY_BIT]
      ##0 no_write_s |=> divider_sync_pulse
      && sync_control_reg[conv_cfg_pkg::DIV_SYNC_EN_BIT])
      else $error("continuous sync lost a pulse or its enable");

   one_shot_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      fire_cond_s ##0 sync_control_reg[conv_cfg_pkg::NEXT_SYNC_ONLY_BIT]
      ##0 no_write_s ##1 (no_write_s [*2])
      |-> ##1 !divider_sync_pulse)
      else $error("one-shot sync passed a second pulse");

   self_clear_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      fire_cond_s ##0 sync_control_reg[conv_cfg_pkg::NEXT_SYNC_ONLY_BIT]
      ##0 no_write_s |=> divider_sync_pulse
      && !sync_control_reg[conv_cfg_pkg::DIV_SYNC_EN_BIT])
      else $error("divider sync enable not cleared after one-shot");

   oe_ignore_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      !user_config_two_reg[conv_cfg_pkg::OE_PIN_EN_BIT] |=> outputs_enabled)
      else $error("output enable pin not ignored");

   oe_follow_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      user_config_two_reg[conv_cfg_pkg::OE_PIN_EN_BIT]
      |=> outputs_enabled == !$past(output_enable_pin_gate_n))
      else $error("outputs do not follow the enable pin");

   osc_detect_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      low_rate_detected |=> low_rate_internal_oscillator_run)
      else $error("oscillator not started on low rate");

   force_osc_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      user_config_two_reg[conv_cfg_pkg::FORCE_OSC_BIT]
      |=> low_rate_internal_oscillator_run)
      else $error("forced oscillator not running");

   pulldown_ctl_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      sdio_pulldown_en != user_config_two_reg[conv_cfg_pkg::PULLDOWN_DIS_BIT])
      else $error("pull-down state disagrees with its bit");

   reserved_zero_a: assert property (
      @(posedge ref_clk) disable iff (reset)
      wr_stb && frame_addr == conv_cfg_pkg::SYNC_CONTROL_ADDR && !sync_fire
      |=> sync_control_reg == ($past(wr_data)
                               & conv_cfg_pkg::SYNC_CONTROL_MASK))
      else $error("sync control write stored reserved bits");

endmodule

// >>> verif/spi_host_model.sv
// Serial control port host that frames register reads and writes
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic ref_clk,
   input  wire logic sdio_out,
   input  wire logic sdio_oe,
   input  wire logic sdio_pulldown_en,
   output logic      serial_clk,
   output logic      serial_select_line_n,
   output logic      sdio_in
);
   // ------------------------------------------------------------
   // Idle levels
   // ------------------------------------------------------------
   initial begin
      serial_clk           = 1'b0;
      serial_select_line_n = 1'b1;
      sdio_in              = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // ------------------------------------------------------------
   // One frame: 16-bit instruction then one data byte, MSB first
   // ------------------------------------------------------------
   task automatic xfer(input  logic        rd,
                       input  logic [12:0] addr,
                       input  logic [7:0]  wdata,
                       output logic [7:0]  rdata);
      logic [23:0] frame;
      frame = {rd, 2'b00, addr, wdata};
      rdata = 8'h00;
      tick(1);
      serial_select_line_n = 1'b0;
      tick(2);
      for (int i = 23; i >= 0; i--) begin
         serial_clk = 1'b0;
         // Released line during read data toggles, never holds a value
         sdio_in = (rd && i < 8) ? i[0] : frame[i];
         tick(2);
         serial_clk = 1'b1;
         if (i < 8) begin
            // Undriven line falls to the pull-down, else reads inverted
            rdata[i] = sdio_oe ? sdio_out
                     : (sdio_pulldown_en ? 1'b0 : ~sdio_out);
         end
         tick(2);
      end
      serial_clk = 1'b0;
      sdio_in = ~sdio_in;
      tick(2);
      serial_select_line_n = 1'b1;
      tick(2);
   endtask
endmodule

// >>> verif/test_sync_and_user_config_regs.sv
// Self-checking bench for the sync and user configuration registers
`timescale 1ns/1ps
module test_sync_and_user_config_regs;
   typedef struct packed {
      logic [12:0] addr;
      logic [7:0]  wdata;
      logic [7:0]  exp;
   } reg_row_t;
   typedef struct packed {
      logic [7:0] val;
      logic [1:0] exp_p;
      logic [7:0] exp_rd;
   } sync_row_t;

   logic       ref_clk;
   logic       reset;
   logic       serial_clk;
   logic       select_n;
   logic       sdio_in;
   logic       sdio_out;
   logic       sdio_oe;
   logic       pd_en;
   logic       sync_in;
   logic       div_pulse;
   logic       oe_pin_n;
   logic       outs_en;
   logic       encode_clk = 1'b0;
   logic       low_rate;
   logic       osc_run;
   logic [7:0] rd_val;
   logic [1:0] pulses;
   int         enc_half;
   int         enc_cnt   = 0;
   int         err_count = 0;
   int         checked   = 0;

   reg_row_t reg_rows [7] = '{
      '{13'h100, 8'hFF, 8'h07}, '{13'h100, 8'h00, 8'h00},
      '{13'h101, 8'hFF, 8'h8D}, '{13'h101, 8'h72, 8'h00},
      '{13'h101, 8'h01, 8'h01}, '{13'h101, 8'h8D, 8'h8D},
      '{13'h0FF, 8'hFF, 8'h00}};
   sync_row_t sync_rows [5] = '{
      '{8'h02, 2'b00, 8'h02}, '{8'h01, 2'b00, 8'h01},
      '{8'h03, 2'b11, 8'h03}, '{8'h07, 2'b10, 8'h05},
      '{8'h06, 2'b00, 8'h06}};

   sync_and_user_config_regs DUT (
      .ref_clk                          (ref_clk),
      .reset                            (reset),
      .serial_clk                       (serial_clk),
      .serial_select_line_n             (select_n),
      .sdio_in                          (sdio_in),
      .sdio_out                         (sdio_out),
      .sdio_oe                          (sdio_oe),
      .sdio_pulldown_en                 (pd_en),
      .sync_in                          (sync_in),
      .divider_sync_pulse               (div_pulse),
      .output_enable_pin_gate_n         (oe_pin_n),
      .outputs_enabled                  (outs_en),
      .encode_clk                       (encode_clk),
      .low_rate_detected                (low_rate),
      .low_rate_internal_oscillator_run (osc_run));

   spi_host_model host (
      .ref_clk              (ref_clk),
      .sdio_out             (sdio_out),
      .sdio_oe              (sdio_oe),
      .sdio_pulldown_en     (pd_en),
      .serial_clk           (serial_clk),
      .serial_select_line_n (select_n),
      .sdio_in              (sdio_in));

   // ------------------------------------------------------------
   // Clock and encode clock; half period zero stops the encode clock
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   always @(negedge ref_clk) begin
      if (enc_half != 0) begin
         if (enc_cnt >= enc_half - 1) begin
            enc_cnt    <= 0;
            encode_clk <= ~encode_clk;
         end else begin
            enc_cnt <= enc_cnt + 1;
         end
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] unused;
      host.xfer(1'b0, a, d, unused);
   endtask

   task automatic rd(input logic [12:0] a, output logic [7:0] d);
      host.xfer(1'b1, a, 8'h00, d);
      check({7'h00, sdio_oe}, 8'h00);
   endtask

   // Any pulse in a short window after one sync edge
   task automatic sync_edge(output logic seen);
      seen    = 1'b0;
      sync_in = 1'b1;
      repeat (4) begin
         tick(1);
         if (div_pulse === 1'b1) begin
            seen = 1'b1;
         end
      end
      sync_in = 1'b0;
      tick(2);
   endtask

   task automatic close_out;
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      reset      = 1'b1;
      sync_in    = 1'b0;
      oe_pin_n   = 1'b0;
      enc_half   = 4;
      tick(5);
      reset = 1'b0;
      foreach (reg_rows[i]) begin
         wr(reg_rows[i].addr, reg_rows[i].wdata);
         rd(reg_rows[i].addr, rd_val);
         check(rd_val, reg_rows[i].exp);
         if (reg_rows[i].addr == conv_cfg_pkg::USER_CONFIG_TWO_ADDR) begin
            check({7'h00, pd_en}, {7'h00, ~reg_rows[i].exp[0]});
         end
      end
      foreach (sync_rows[i]) begin
         wr(conv_cfg_pkg::SYNC_CONTROL_ADDR, sync_rows[i].val);
         sync_edge(pulses[1]);
         rd(conv_cfg_pkg::SYNC_CONTROL_ADDR, rd_val);
         sync_edge(pulses[0]);
         check({6'h00, pulses}, {6'h00, sync_rows[i].exp_p});
         check(rd_val, sync_rows[i].exp_rd);
      end
      // Second reset in mid-run
      oe_pin_n = 1'b1;
      reset    = 1'b1;
      tick(2);
      check({3'h0, outs_en, pd_en, div_pulse, osc_run, low_rate}, 8'h18);
      reset = 1'b0;
      rd(conv_cfg_pkg::SYNC_CONTROL_ADDR, rd_val);
      check(rd_val, conv_cfg_pkg::SYNC_CONTROL_RESET);
      rd(conv_cfg_pkg::USER_CONFIG_TWO_ADDR, rd_val);
      check(rd_val, conv_cfg_pkg::USER_CONFIG_TWO_RESET);
      check({7'h00, outs_en}, 8'h00);
      oe_pin_n = 1'b0;
      tick(2);
      check({7'h00, outs_en}, 8'h01);
      wr(conv_cfg_pkg::USER_CONFIG_TWO_ADDR, 8'h08);
      oe_pin_n = 1'b1;
      tick(2);
      check({7'h00, outs_en}, 8'h01);
      // Encode period 24 cycles stays fast, 26 cycles is slow
      enc_half = 12;
      tick(80);
      check({6'h00, low_rate, osc_run}, 8'h00);
      enc_half = 13;
      tick(80);
      check({6'h00, low_rate, osc_run}, 8'h03);
      wr(conv_cfg_pkg::USER_CONFIG_TWO_ADDR, 8'h00);
      tick(2);
      check({6'h00, low_rate, osc_run}, 8'h00);
      wr(conv_cfg_pkg::USER_CONFIG_TWO_ADDR, 8'h04);
      tick(2);
      check({6'h00, low_rate, osc_run}, 8'h01);
      enc_half = 0;
      wr(conv_cfg_pkg::USER_CONFIG_TWO_ADDR, 8'h08);
      tick(40);
      check({6'h00, low_rate, osc_run}, 8'h03);
      close_out();
   end

   initial begin
      #800000;
      err_count++;
      close_out();
   end
endmodule
